// ### hw/gpio_port_pkg.sv
package gpio_port_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFS_PORT_OUTPUT_VALUE   = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_BIT_SETTER   = 8'h04;
  localparam logic [7:0] OFS_OUTPUT_BIT_CLEARER  = 8'h08;
  localparam logic [7:0] OFS_OUTPUT_BIT_TOGGLER  = 8'h0C;
  localparam logic [7:0] OFS_PAD_LEVEL_READBACK  = 8'h10;
  localparam logic [7:0] OFS_DRIVE_MODE_CONFIG   = 8'h14;
  localparam logic [7:0] OFS_INPUT_BUFFER_CONFIG = 8'h18;
  localparam logic [7:0] OFS_PIN_FUNCTION_SELECT = 8'h1C;

  // port geometry
  localparam int PORT_PINS   = 8;
  localparam int FUNC_BITS   = 4;
  localparam int DATA_BITS   = 32;

  // reset values
  localparam logic [7:0]  RST_OUTPUT_VALUE = 8'h00;
  localparam logic [7:0]  RST_DRIVE_EN     = 8'h00;
  localparam logic [7:0]  RST_INBUF_EN     = 8'hFF;
  localparam logic [31:0] RST_FUNC_SEL     = 32'h0000_0000;

  // per-pin function codes of the pin function matrix
  typedef enum logic [3:0] {
    FN_FIRMWARE     = 4'b0000,
    FN_SERIAL       = 4'b0001,
    FN_TIMER        = 4'b0010,
    FN_LCD_COMMON   = 4'b0011,
    FN_LCD_SEGMENT  = 4'b0100,
    FN_AMUX_A       = 4'b0101,
    FN_AMUX_B       = 4'b0110,
    FN_TOUCH_SENSE  = 4'b0111,
    FN_TOUCH_SHIELD = 4'b1000,
    FN_TOUCH_COMP   = 4'b1001
  } pin_function_e;

  // operating mode reported by the serial comm block
  typedef enum logic [1:0] {
    SERIAL_OFF        = 2'b00,
    SERIAL_UART       = 2'b01,
    SERIAL_SPI_MASTER = 2'b10,
    SERIAL_SPI_SLAVE  = 2'b11
  } serial_mode_e;

endpackage : gpio_port_pkg

// ### hw/pad_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pad_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stageOne;

  // two flops; stageOne feeds nothing but syncOut
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stageOne <= '0;
      syncOut  <= '0;
    end else begin
      stageOne <= asyncIn;
      syncOut  <= stageOne;
    end
  end

endmodule : pad_sync

`default_nettype wire

// ### hw/gpio_port.sv
//
// Overview of operation
// RL1: writing output value updates every pin
// RL2: output value reads back stored, not pads
// RL3: set, clear, toggle ports act on ones
// RL4: pad readback returns sampled pad levels
// RL5: writes to pad readback change nothing
// RL6: serial UART mode disables receive driver
// RL7: SPI disables MISO or MOSI/select drivers
// RL8: serial disable overrides programmed drive
// RL9: timer input pins lose output driver
// RL10: software sets analog mode for analog pins
// RL11: software routes analog pins to mux bus
// RL12: every pin selectable for LCD drive
// RL13: software configures touch pins and routing
// RL14: port has eight pins, eight-bit fields
// RL15: set/clear/toggle visible on next read
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int PINS     = PORT_PINS,
  parameter int RX_PIN   = 0,
  parameter int MISO_PIN = 1,
  parameter int MOSI_PIN = 2,
  parameter int SEL_PIN  = 3
) (
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [DATA_BITS-1:0]      pwdata,
  output var  logic [DATA_BITS-1:0]      prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  // pads
  input  wire logic [PINS-1:0]           padIn,
  output var  logic [PINS-1:0]           padOut,
  output var  logic [PINS-1:0]           padOe,
  // peripherals on the same clock
  input  wire logic [1:0]                serialMode,
  input  wire logic [PINS-1:0]           serialOut,
  input  wire logic [PINS-1:0]           serialOe,
  input  wire logic [PINS-1:0]           timerOut,
  input  wire logic [PINS-1:0]           timerOe,
  input  wire logic [PINS-1:0]           timerInputPins,
  input  wire logic [PINS-1:0]           lcdLevel,
  // routing state towards lcd and analog side
  output var  logic [PINS-1:0]           lcdDrive,
  output var  logic [PINS*FUNC_BITS-1:0] pinFunction
);

  // field widths must fit one bus word; refused at elaboration, not at run time
  if (PINS != PORT_PINS || PINS * FUNC_BITS > DATA_BITS) begin : g_bad_pins
    $error("gpio_port: PINS must be 8");
  end
  if (RX_PIN >= PINS || MISO_PIN >= PINS ||
      MOSI_PIN >= PINS || SEL_PIN >= PINS) begin : g_bad_idx
    $error("gpio_port: serial pin index out of range");
  end

  typedef struct packed {
    logic [PINS-1:0]           outVal;
    logic [PINS-1:0]           driveEn;
    logic [PINS-1:0]           inBufEn;
    logic [PINS*FUNC_BITS-1:0] funcSel;
    logic [DATA_BITS-1:0]      rdata;
    logic                      ready;
    logic                      slvErr;
    logic [PINS-1:0]           padOut;
    logic [PINS-1:0]           padOe;
    logic [PINS-1:0]           lcdDrive;
  } port_state_s;

  port_state_s st;
  port_state_s next_st;

  logic [PINS-1:0] padSync;
  logic [PINS-1:0] padLevel;
  logic            setupPhase;
  logic            writeDone;
  logic            addrMapped;

  // pads come from outside the clock domain
  pad_sync #(
    .WIDTH (PINS)
  ) u_pad_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .asyncIn (padIn),
    .syncOut (padSync)
  );

  // a disabled input buffer reads as low
  assign padLevel   = padSync & st.inBufEn;
  assign setupPhase = psel & ~penable;
  assign writeDone  = psel & penable & st.ready & pwrite;

  always_comb begin
    unique case (paddr)
      OFS_PORT_OUTPUT_VALUE, OFS_OUTPUT_BIT_SETTER, OFS_OUTPUT_BIT_CLEARER,
      OFS_OUTPUT_BIT_TOGGLER, OFS_PAD_LEVEL_READBACK, OFS_DRIVE_MODE_CONFIG,
      OFS_INPUT_BUFFER_CONFIG, OFS_PIN_FUNCTION_SELECT: addrMapped = 1'b1;
      default:                                          addrMapped = 1'b0;
    endcase
  end

  // bus slave, register writes and pad muxing
  always_comb begin
    pin_function_e fn;
    logic          forceOff;
    next_st        = st;
    fn             = FN_FIRMWARE;
    forceOff       = 1'b0;
    next_st.ready  = 1'b0;
    next_st.slvErr = 1'b0;

    // read data sampled in setup; answer in the first access cycle
    if (setupPhase) begin
      next_st.ready  = 1'b1;
      next_st.slvErr = ~addrMapped;
      next_st.rdata  = '0;
      if (!pwrite) begin
        unique case (paddr)
          OFS_PORT_OUTPUT_VALUE:   next_st.rdata[PINS-1:0] = st.outVal;  // [RL2]
          OFS_PAD_LEVEL_READBACK:  next_st.rdata[PINS-1:0] = padLevel;   // [RL4]
          OFS_DRIVE_MODE_CONFIG:   next_st.rdata[PINS-1:0] = st.driveEn;
          OFS_INPUT_BUFFER_CONFIG: next_st.rdata[PINS-1:0] = st.inBufEn;
          OFS_PIN_FUNCTION_SELECT: next_st.rdata           = st.funcSel;
          default:                 next_st.rdata           = '0;
        endcase
      end
    end

    // writes land at the access edge; set/clear/toggle touch ones only
    if (writeDone) begin
      unique case (paddr)
        OFS_PORT_OUTPUT_VALUE:   next_st.outVal  = pwdata[PINS-1:0];              // [RL1]
        OFS_OUTPUT_BIT_SETTER:   next_st.outVal  = st.outVal | pwdata[PINS-1:0];  // [RL3] [RL15]
        OFS_OUTPUT_BIT_CLEARER:  next_st.outVal  = st.outVal & ~pwdata[PINS-1:0]; // [RL3] [RL15]
        OFS_OUTPUT_BIT_TOGGLER:  next_st.outVal  = st.outVal ^ pwdata[PINS-1:0];  // [RL3] [RL15]
        OFS_DRIVE_MODE_CONFIG:   next_st.driveEn = pwdata[PINS-1:0];
        OFS_INPUT_BUFFER_CONFIG: next_st.inBufEn = pwdata[PINS-1:0];
        OFS_PIN_FUNCTION_SELECT: next_st.funcSel = pwdata;
        default:                 next_st.outVal  = st.outVal;                     // [RL5]
      endcase
    end

    // per-pin driver selection; eight identical lanes
    for (int i = 0; i < PINS; i++) begin                                          // [RL14]
      fn       = pin_function_e'(st.funcSel[i*FUNC_BITS +: FUNC_BITS]);
      forceOff = 1'b0;
      next_st.lcdDrive[i] = 1'b0;
      unique case (fn)
        FN_FIRMWARE: begin
          next_st.padOut[i] = st.outVal[i];
          next_st.padOe[i]  = st.driveEn[i];
        end
        FN_SERIAL: begin
          next_st.padOut[i] = serialOut[i];
          next_st.padOe[i]  = serialOe[i];
        end
        FN_TIMER: begin
          next_st.padOut[i] = timerOut[i];
          next_st.padOe[i]  = timerOe[i];
        end
        FN_LCD_COMMON, FN_LCD_SEGMENT: begin
          next_st.padOut[i]   = lcdLevel[i];                                      // [RL12]
          next_st.padOe[i]    = 1'b1;
          next_st.lcdDrive[i] = 1'b1;
        end
        // analog and touch routes leave the digital driver off
        default: begin
          next_st.padOut[i] = 1'b0;
          next_st.padOe[i]  = 1'b0;
        end
      endcase
      // serial block input pins stay high impedance
      unique case (serialMode)
        SERIAL_UART:       forceOff = (i == RX_PIN);                              // [RL6]
        SERIAL_SPI_MASTER: forceOff = (i == MISO_PIN);                            // [RL7]
        SERIAL_SPI_SLAVE:  forceOff = (i == MOSI_PIN) || (i == SEL_PIN);          // [RL7]
        SERIAL_OFF:        forceOff = 1'b0;
      endcase
      // timer input pins act as high-z digital only
      if (forceOff || timerInputPins[i]) begin                                    // [RL8] [RL9]
        next_st.padOe[i] = 1'b0;
      end
    end
  end

  // whole state registered in one place
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st          <= '0;
      st.outVal   <= RST_OUTPUT_VALUE;
      st.driveEn  <= RST_DRIVE_EN;
      st.inBufEn  <= RST_INBUF_EN;
      st.funcSel  <= RST_FUNC_SEL;
    end else begin
      st <= next_st;
    end
  end

  assign prdata      = st.rdata;
  assign pready      = st.ready;
  assign pslverr     = st.slvErr;
  assign padOut      = st.padOut;
  assign padOe       = st.padOe;
  assign lcdDrive    = st.lcdDrive;
  assign pinFunction = st.funcSel;

  // checks on the bus, value and pad paths
  logic accessRead;
  assign accessRead = psel & penable & st.ready & ~pwrite;

  property p_write_value;
    @(posedge sys_clk) disable iff (!nrst)
      writeDone && paddr == OFS_PORT_OUTPUT_VALUE |=> st.outVal == $past(pwdata[PINS-1:0]);
  endproperty
  a_write_value: assert property (p_write_value) else $error("value write lost"); // [RL1]

  property p_read_value;
    @(posedge sys_clk) disable iff (!nrst)
      accessRead && paddr == OFS_PORT_OUTPUT_VALUE |-> prdata[PINS-1:0] == st.outVal;
  endproperty
  a_read_value: assert property (p_read_value) else $error("value read mismatch"); // [RL2]

  property p_set_bits;
    @(posedge sys_clk) disable iff (!nrst)
      writeDone && paddr == OFS_OUTPUT_BIT_SETTER |=>
        st.outVal == ($past(st.outVal) | $past(pwdata[PINS-1:0]));
  endproperty
  a_set_bits: assert property (p_set_bits) else $error("set port wrong"); // [RL3]

  property p_clear_toggle;
    @(posedge sys_clk) disable iff (!nrst)
      writeDone && (paddr == OFS_OUTPUT_BIT_CLEARER || paddr == OFS_OUTPUT_BIT_TOGGLER) |=>
        st.outVal == (($past(paddr) == OFS_OUTPUT_BIT_CLEARER)
                      ? ($past(st.outVal) & ~$past(pwdata[PINS-1:0]))
                      : ($past(st.outVal) ^ $past(pwdata[PINS-1:0])));
  endproperty
  a_clear_toggle: assert property (p_clear_toggle) else $error("clear/toggle wrong"); // [RL3]

  property p_pad_read;
    @(posedge sys_clk) disable iff (!nrst)
      setupPhase && !pwrite && paddr == OFS_PAD_LEVEL_READBACK |=>
        pready && prdata == {{(DATA_BITS-PINS){1'b0}}, $past(padLevel)};
  endproperty
  a_pad_read: assert property (p_pad_read) else $error("pad read wrong"); // [RL4]

  property p_pad_write;
    @(posedge sys_clk) disable iff (!nrst)
      writeDone && paddr == OFS_PAD_LEVEL_READBACK |=> $stable(st.outVal) && $stable(st.funcSel);
  endproperty
  a_pad_write: assert property (p_pad_write) else $error("pad write had effect"); // [RL5]

  property p_uart_rx;
    @(posedge sys_clk) disable iff (!nrst)
      serialMode == SERIAL_UART |=> !padOe[RX_PIN];
  endproperty
  a_uart_rx: assert property (p_uart_rx) else $error("uart rx driven"); // [RL6] [RL8]

  property p_spi_pins;
    @(posedge sys_clk) disable iff (!nrst)
      (serialMode == SERIAL_SPI_MASTER |=> !padOe[MISO_PIN]) and
      (serialMode == SERIAL_SPI_SLAVE |=> !padOe[MOSI_PIN] && !padOe[SEL_PIN]);
  endproperty
  a_spi_pins: assert property (p_spi_pins) else $error("spi input driven"); // [RL7]

  property p_timer_in;
    @(posedge sys_clk) disable iff (!nrst)
      timerInputPins != '0 |=> (padOe & $past(timerInputPins)) == '0;
  endproperty
  a_timer_in: assert property (p_timer_in) else $error("timer input driven"); // [RL9]

  property p_lcd_pin;
    @(posedge sys_clk) disable iff (!nrst)
      st.funcSel[FUNC_BITS-1:0] == FN_LCD_SEGMENT && timerInputPins[0] == 1'b0
        && !(serialMode == SERIAL_UART && RX_PIN == 0) |=>
        lcdDrive[0] && padOe[0] && padOut[0] == $past(lcdLevel[0]);
  endproperty
  a_lcd_pin: assert property (p_lcd_pin) else $error("lcd pin not driven"); // [RL12]

  property p_rmw_read;
    @(posedge sys_clk) disable iff (!nrst)
      writeDone && paddr == OFS_OUTPUT_BIT_SETTER ##2
        setupPhase && !pwrite && paddr == OFS_PORT_OUTPUT_VALUE |=>
        (prdata[PINS-1:0] & $past(pwdata[PINS-1:0], 3)) == $past(pwdata[PINS-1:0], 3);
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("set not seen on read"); // [RL15]

  property p_value_hold;
    @(posedge sys_clk) disable iff (!nrst)
      !writeDone |=> $stable(st.outVal);
  endproperty
  a_value_hold: assert property (p_value_hold) else $error("value moved unasked"); // [RL1] [RL5]

  property p_fw_pad;
    @(posedge sys_clk) disable iff (!nrst)
      st.funcSel[FUNC_BITS-1:0] == FN_FIRMWARE |=> padOut[0] == $past(st.outVal[0]);
  endproperty
  a_fw_pad: assert property (p_fw_pad) else $error("firmware pin not following value"); // [RL1]

  property p_fw_oe;
    @(posedge sys_clk) disable iff (!nrst)
      st.funcSel[MOSI_PIN*FUNC_BITS +: FUNC_BITS] == FN_FIRMWARE && st.driveEn[MOSI_PIN]
        && !timerInputPins[MOSI_PIN] && serialMode == SERIAL_OFF |=> padOe[MOSI_PIN];
  endproperty
  a_fw_oe: assert property (p_fw_oe) else $error("enabled driver not on"); // [RL8]

  property p_inbuf_off;
    @(posedge sys_clk) disable iff (!nrst)
      setupPhase && !pwrite && paddr == OFS_PAD_LEVEL_READBACK && !st.inBufEn[PINS-1] |=>
        !prdata[PINS-1];
  endproperty
  a_inbuf_off: assert property (p_inbuf_off) else $error("disabled buffer read high"); // [RL4]

  property p_upper_zero;
    @(posedge sys_clk) disable iff (!nrst)
      pready && paddr == OFS_PAD_LEVEL_READBACK |-> prdata[DATA_BITS-1:PINS] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("pad read above pin 7"); // [RL14]

  property p_pad_write_err;
    @(posedge sys_clk) disable iff (!nrst)
      writeDone && paddr == OFS_PAD_LEVEL_READBACK |-> !pslverr;
  endproperty
  a_pad_write_err: assert property (p_pad_write_err) else $error("pad write errored"); // [RL5]

  property p_lcd_off;
    @(posedge sys_clk) disable iff (!nrst)
      st.funcSel[FUNC_BITS-1:0] != FN_LCD_COMMON && st.funcSel[FUNC_BITS-1:0] != FN_LCD_SEGMENT
        |=> !lcdDrive[0];
  endproperty
  a_lcd_off: assert property (p_lcd_off) else $error("lcd drive without lcd route"); // [RL12]

  property p_lcd_common;
    @(posedge sys_clk) disable iff (!nrst)
      st.funcSel[PINS*FUNC_BITS-1 -: FUNC_BITS] == FN_LCD_COMMON |=> lcdDrive[PINS-1];
  endproperty
  a_lcd_common: assert property (p_lcd_common) else $error("lcd common not driven"); // [RL12]

endmodule : gpio_port

`default_nettype wire

// ### test/pad_circuit.sv
`timescale 1ns/1ps
`default_nettype none

module pad_circuit (
  input  wire logic [7:0] padOut,
  input  wire logic [7:0] padOe,
  input  wire logic [7:0] extLevel,
  output var  logic [7:0] padLevel
);
  // wired pins: the port wins where it drives, the weak outside source elsewhere
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      padLevel[i] = padOe[i] ? padOut[i] : extLevel[i];
    end
  end
endmodule : pad_circuit

`default_nettype wire

// ### test/tb_gpio_port_data_and_pin_ownership.sv
`timescale 1ns/1ps
`default_nettype none

module tb_gpio_port_data_and_pin_ownership;
  import gpio_port_pkg::*;
  logic        sys_clk, nrst, psel, penable, pwrite, pslverr, pready;
  logic [7:0]  paddr, padIn, padOut, padOe, ext, tIn, lcdDrive;
  logic [7:0]  serOut, serOe, tmrOut, tmrOe, lcdLvl;
  logic [1:0]  serialMode;
  logic [31:0] pwdata, prdata, pinFunction, rdv;
  logic        errv;
  int          miscompares, samplesChecked;

  gpio_port i_gpio_port (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .serialMode(serialMode), .serialOut(serOut), .serialOe(serOe), .timerOut(tmrOut),
    .timerOe(tmrOe), .timerInputPins(tIn), .lcdLevel(lcdLvl), .lcdDrive(lcdDrive),
    .pinFunction(pinFunction));
  pad_circuit i_pad_circuit (.padOut(padOut), .padOe(padOe), .extLevel(ext),
    .padLevel(padIn));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("MISMATCH pready expected 1 seen %b", pready);
      test_done();
    end else begin
      rdv = prdata;
      errv = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(name, exp, rdv);
  endtask : rd

  // pads and outputs follow within two edges; three gives margin
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : settle

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    static logic [7:0] ofs[3] = '{OFS_OUTPUT_BIT_SETTER, OFS_OUTPUT_BIT_CLEARER,
                                  OFS_OUTPUT_BIT_TOGGLER};
    static logic [7:0] dat[3] = '{8'h0A, 8'h81, 8'hFF};
    static logic [7:0] res[3] = '{8'hAF, 8'h2E, 8'hD1};
    static logic [7:0] msk[3] = '{8'h01, 8'h02, 8'h0C};
    {psel, penable, pwrite, paddr, pwdata, serialMode, tIn} = '0;
    ext = 8'h3C;
    {serOut, serOe, tmrOut, tmrOe, lcdLvl} = {8'h06, 8'h0F, 8'h90, 8'hF0, 8'hA5};
    nrst = 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rd("outval", OFS_PORT_OUTPUT_VALUE, 32'h0000_0000);
    rd("drive", OFS_DRIVE_MODE_CONFIG, 32'h0000_0000);
    rd("inbuf", OFS_INPUT_BUFFER_CONFIG, 32'h0000_00FF);
    rd("func", OFS_PIN_FUNCTION_SELECT, 32'h0000_0000);
    // upper pins undriven so the pads differ from the stored value
    apb(1'b1, OFS_PORT_OUTPUT_VALUE, 32'h0000_00A5);
    apb(1'b1, OFS_DRIVE_MODE_CONFIG, 32'h0000_000F);
    settle();
    check("padOut", 32'h0000_00A5, padOut);
    check("padOe", 32'h0000_000F, padOe);
    rd("outval", OFS_PORT_OUTPUT_VALUE, 32'h0000_00A5);
    rd("padlevel", OFS_PAD_LEVEL_READBACK, 32'h0000_0035);
    // set, clear, toggle each followed at once by a read
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ofs[i], {24'h00_0000, dat[i]});
      rd("outval", OFS_PORT_OUTPUT_VALUE, {24'h00_0000, res[i]});
    end
    rd("setter", OFS_OUTPUT_BIT_SETTER, 32'h0000_0000);
    apb(1'b1, OFS_PAD_LEVEL_READBACK, 32'h0000_00FF);
    check("pserr", 32'h0000_0000, errv);
    rd("outval", OFS_PORT_OUTPUT_VALUE, 32'h0000_00D1);
    settle();
    check("padOut", 32'h0000_00D1, padOut);
    apb(1'b1, 8'h40, 32'h0000_00FF);
    check("pserr", 32'h0000_0001, errv);
    rd("unmapped", 8'h40, 32'h0000_0000);
    check("pserr", 32'h0000_0001, errv);
    // forced-off drivers beat an all-on drive enable
    apb(1'b1, OFS_DRIVE_MODE_CONFIG, 32'h0000_00FF);
    for (int m = 1; m < 4; m++) begin
      @(posedge sys_clk);
      serialMode <= m[1:0];
      settle();
      check("padOe", {24'h00_0000, ~msk[m-1]}, padOe);
    end
    @(posedge sys_clk);
    serialMode <= SERIAL_OFF;
    tIn <= 8'h80;
    settle();
    check("padOe", 32'h0000_007F, padOe);
    for (int c = 3; c < 5; c++) begin
      apb(1'b1, OFS_PIN_FUNCTION_SELECT, {8{c[3:0]}});
      settle();
      check("lcdDrive", 32'h0000_00FF, lcdDrive);
      check("padOut", 32'h0000_00A5, padOut);
      check("padOe", 32'h0000_007F, padOe);
      check("pinFunction", {8{c[3:0]}}, pinFunction);
      rd("func", OFS_PIN_FUNCTION_SELECT, {8{c[3:0]}});
    end
    // pins 0-3 lent to the serial block, 4-7 to the timer
    apb(1'b1, OFS_PIN_FUNCTION_SELECT, 32'h2222_1111);
    settle();
    check("padOut", 32'h0000_0096, padOut);
    check("padOe", 32'h0000_007F, padOe);
    @(posedge sys_clk);
    serialMode <= SERIAL_UART;
    settle();
    check("padOe", 32'h0000_007E, padOe);
    // analog and touch routes: software drops all drivers and the input buffers of pins 4-7
    @(posedge sys_clk);
    serialMode <= SERIAL_OFF;
    apb(1'b1, OFS_PIN_FUNCTION_SELECT, 32'h9876_5555);
    apb(1'b1, OFS_DRIVE_MODE_CONFIG, 32'h0000_0000);
    apb(1'b1, OFS_INPUT_BUFFER_CONFIG, 32'h0000_000F);
    settle();
    check("padOe", 32'h0000_0000, padOe);
    check("lcdDrive", 32'h0000_0000, lcdDrive);
    rd("padlevel", OFS_PAD_LEVEL_READBACK, 32'h0000_000C);
    // second reset in mid-run brings every register back
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rd("outval", OFS_PORT_OUTPUT_VALUE, 32'h0000_0000);
    rd("inbuf", OFS_INPUT_BUFFER_CONFIG, 32'h0000_00FF);
    check("pinFunction", 32'h0000_0000, pinFunction);
    check("padOe", 32'h0000_0000, padOe);
    test_done();
  end
endmodule : tb_gpio_port_data_and_pin_ownership

`default_nettype wire
